// File: rtl/acs_pkg.sv
// constants and types shared by the conversion sequencer files
// assumes a single 50 MHz system clock
`default_nettype none
package acs_pkg;
	localparam int          ACS_CLOCK_HZ     = 50_000_000;
	localparam int          ACS_DIV_W        = 3;
	localparam int          ACS_PRESCALE_W   = 7;
	localparam int          ACS_SAMPLE_CLKS  = 4;
	localparam int          ACS_CONVERT_CLKS = 12;
	localparam int          ACS_TOTAL_CLKS   = ACS_SAMPLE_CLKS + ACS_CONVERT_CLKS;
	localparam int          ACS_CNT_W        = 5;
	localparam int          ACS_RESULT_W     = 12;
	localparam logic [6:0]  ACS_PRESCALE_0   = 7'h00;
	localparam logic [4:0]  ACS_CNT_0        = 5'h00;
	localparam logic [4:0]  ACS_CNT_1        = 5'h01;
	localparam logic [11:0] ACS_RESULT_0     = 12'h000;

	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_ARMED,
		ACS_SAMPLE,
		ACS_CONVERT
	} acs_phase_t;
endpackage
`default_nettype wire

// File: rtl/acs_tick_if.sv
// carries the converter clock tick from the divider to the sequencer
// assumes both ends share the system clock
`default_nettype none
interface acs_tick_if;
	logic [2:0] divider_select;
	logic       run;
	logic       tick;
	modport divider (input divider_select, input run, output tick);
	modport sequencer (output divider_select, output run, input tick);
endinterface
`default_nettype wire

// File: rtl/acs_clock_divider.sv
// converter clock prescaler: one tick every 2**select system clocks
// assumes select is stable while run is high
`default_nettype none
module acs_clock_divider
	import acs_pkg::*;
(
	// system
	input  wire logic     clock,
	input  wire logic     rst,
	// link to the sequencer
	acs_tick_if.divider   link
);
	typedef struct packed {
		logic [ACS_PRESCALE_W-1:0] count;
	} acs_div_state_t;

	acs_div_state_t state;
	acs_div_state_t next_state;
	logic [ACS_PRESCALE_W-1:0] limit;

	function automatic logic [ACS_PRESCALE_W-1:0] div_limit(
		input logic [ACS_DIV_W-1:0] sel);
		div_limit = ACS_PRESCALE_W'((1 << sel) - 1);
	endfunction

	assign limit = div_limit(link.divider_select);

	always_comb begin
		next_state = state;
		if (!link.run || state.count >= limit) begin
			next_state.count = ACS_PRESCALE_0;
		end else begin
			next_state.count = state.count + 1'b1;
		end
	end

	// tick is combinational so the sequencer sees it in the same cycle
	assign link.tick = link.run && (state.count >= limit);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
		link.tick && link.divider_select == 3'h1 && link.run
		|=> !link.tick)
		else $error("tick came too soon for divide by two");
endmodule
`default_nettype wire

// File: rtl/acs_sequencer.sv
// conversion sequencer: start handshake, busy flag, timing, completion
// assumes control inputs are synchronous to clock; analog core outside
`default_nettype none
module acs_sequencer
	import acs_pkg::*;
(
	// system
	input  wire logic                    clock,
	input  wire logic                    rst,
	// control bits
	input  wire logic                    converter_power_enable,
	input  wire logic                    start,
	input  wire logic [ACS_DIV_W-1:0]    converter_clock_divider_select,
	input  wire logic                    interrupt_enable,
	input  wire logic                    global_interrupt_enable,
	input  wire logic                    request_flag_clear,
	// analog core
	input  wire logic [ACS_RESULT_W-1:0] core_result,
	output logic                         core_power,
	output logic                         core_sample,
	output logic                         core_convert_step,
	// status
	output logic                         conversion_busy_flag,
	output logic                         request_flag,
	output logic                         interrupt,
	output logic                         conversion_done,
	output logic [ACS_RESULT_W-1:0]      result
);
	typedef struct packed {
		acs_phase_t                  phase;
		logic [ACS_CNT_W-1:0]        clocks;
		logic                        busy;
		logic                        flag;
		logic                        irq;
		logic                        done;
		logic [ACS_RESULT_W-1:0]     result;
	} acs_seq_state_t;

	acs_seq_state_t state;
	acs_seq_state_t next_state;
	logic           tick;
	logic           finish;

	acs_tick_if link ();

	acs_clock_divider u_divider (
		.clock (clock),
		.rst   (rst),
		.link  (link)
	);

	assign link.divider_select = converter_clock_divider_select;
	assign link.run = state.phase == ACS_SAMPLE ||
	                  state.phase == ACS_CONVERT;
	assign tick = link.tick;
	assign finish = state.phase == ACS_CONVERT && tick &&
	                state.clocks == ACS_CNT_W'(ACS_TOTAL_CLKS - 1);

	always_comb begin
		next_state      = state;
		next_state.done = 1'b0;
		next_state.irq  = 1'b0;
		case (state.phase)
			ACS_IDLE: begin
				if (converter_power_enable && start) begin
					next_state.phase = ACS_ARMED;
				end
			end
			ACS_ARMED: begin
				if (!start) begin
					next_state.phase  = ACS_SAMPLE;
					next_state.clocks = ACS_CNT_0;
					next_state.busy   = 1'b1;
				end
			end
			ACS_SAMPLE: begin
				if (tick) begin
					next_state.clocks = state.clocks + ACS_CNT_1;
					if (state.clocks == ACS_CNT_W'(ACS_SAMPLE_CLKS - 1)) begin
						next_state.phase = ACS_CONVERT;
					end
				end
			end
			ACS_CONVERT: begin
				if (tick) begin
					next_state.clocks = state.clocks + ACS_CNT_1;
				end
				if (finish) begin
					next_state.phase  = ACS_IDLE;
					next_state.busy   = 1'b0;
					next_state.done   = 1'b1;
					next_state.result = core_result;
					next_state.irq    = interrupt_enable &&
					                    global_interrupt_enable;
				end
			end
			default: begin
				next_state.phase = ACS_IDLE;
			end
		endcase
		// set wins over a clear in the same cycle while powered; with power off a finish never sets the flag
		if (request_flag_clear) begin
			next_state.flag = 1'b0;
		end
		if (finish) begin
			next_state.flag = 1'b1;
		end
		// power loss aborts the run and holds busy low; a finishing cycle still loads result
		if (!converter_power_enable) begin
			next_state.phase  = ACS_IDLE;
			next_state.busy   = 1'b0;
			next_state.done   = 1'b0;
			next_state.irq    = 1'b0;
			next_state.clocks = ACS_CNT_0;
			if (!request_flag_clear || finish) begin
				next_state.flag = state.flag;
			end
			if (request_flag_clear) begin
				next_state.flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '{phase: ACS_IDLE, clocks: ACS_CNT_0, busy: 1'b0,
			           flag: 1'b0, irq: 1'b0, done: 1'b0,
			           result: ACS_RESULT_0};
		end else begin
			state <= next_state;
		end
	end

	assign core_power           = converter_power_enable;
	// runs on its own; processor only watches the flags
	assign core_sample          = state.phase == ACS_SAMPLE;
	assign core_convert_step    = state.phase == ACS_CONVERT && tick;
	assign conversion_busy_flag = state.busy;
	assign request_flag         = state.flag;
	assign interrupt            = state.irq;
	assign conversion_done      = state.done;
	assign result               = state.result;

	a_busy_rises: assert property (@(posedge clock) disable iff (rst)
		state.phase == ACS_ARMED && !start && converter_power_enable
		|=> conversion_busy_flag)
		else $error("busy did not rise after start pulse");

	a_busy_holds: assert property (@(posedge clock) disable iff (rst)
		(state.phase == ACS_SAMPLE || state.phase == ACS_CONVERT)
		|-> conversion_busy_flag)
		else $error("busy low during conversion");

	// a power drop in the finishing cycle is an abort, not a completion
	a_busy_falls: assert property (@(posedge clock) disable iff (rst)
		finish && converter_power_enable
		|=> !conversion_busy_flag && conversion_done)
		else $error("busy not cleared at completion");

	a_done_pulse: assert property (@(posedge clock) disable iff (rst)
		conversion_done |=> !conversion_done)
		else $error("done held longer than one cycle");

	a_flag_set: assert property (@(posedge clock) disable iff (rst)
		finish && converter_power_enable |=> request_flag)
		else $error("request flag not set at completion");

	a_irq_raise: assert property (@(posedge clock) disable iff (rst)
		finish && converter_power_enable && interrupt_enable
		&& global_interrupt_enable |=> interrupt)
		else $error("interrupt missing at enabled completion");

	a_armed_wait: assert property (@(posedge clock) disable iff (rst)
		state.phase == ACS_ARMED && start |=> !conversion_busy_flag)
		else $error("busy rose before start fell");

	a_irq_gate: assert property (@(posedge clock) disable iff (rst)
		interrupt |-> $past(finish) && $past(interrupt_enable)
		&& $past(global_interrupt_enable))
		else $error("interrupt without enables or completion");

	a_need_start: assert property (@(posedge clock) disable iff (rst)
		$rose(conversion_busy_flag) |-> $past(state.phase == ACS_ARMED)
		&& !$past(start))
		else $error("busy rose without full start pulse");

	a_power_off: assert property (@(posedge clock) disable iff (rst)
		!converter_power_enable |=> !conversion_busy_flag)
		else $error("busy high while unpowered");

	a_phase_split: assert property (@(posedge clock) disable iff (rst)
		state.phase == ACS_SAMPLE && $past(state.phase) == ACS_CONVERT
		|-> 1'b0)
		else $error("sampling followed conversion");

	a_sample_len: assert property (@(posedge clock) disable iff (rst)
		$rose(state.phase == ACS_CONVERT) |-> state.clocks
		== ACS_CNT_W'(ACS_SAMPLE_CLKS))
		else $error("sampling phase not four converter clocks");

	a_power_pin: assert property (@(posedge clock) disable iff (rst)
		core_power == converter_power_enable)
		else $error("core power does not follow enable");
endmodule
`default_nettype wire

// File: tb/tb_acs_sequencer.sv
// self-checking bench for the conversion sequencer top module
// assumes the package and design files are compiled first
`default_nettype none
module tb_acs_sequencer
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                    clock = 1'b0;
	logic                    rst = 1'b1;
	logic                    power = 1'b0;
	logic                    start = 1'b0;
	logic [ACS_DIV_W-1:0]    sel = 3'h0;
	logic                    ie = 1'b0;
	logic                    ge = 1'b1;
	logic                    clr = 1'b0;
	logic [ACS_RESULT_W-1:0] core_result = 12'h000;
	logic                    core_power;
	logic                    core_sample;
	logic                    core_step;
	logic                    busy;
	logic                    flag;
	logic                    irq;
	logic                    done;
	logic [ACS_RESULT_W-1:0] result;
	int                      fails = 0;
	int                      n_compared = 0;
	int                      cycles = 0;

	acs_sequencer dut (
		.clock                          (clock),
		.rst                            (rst),
		.converter_power_enable         (power),
		.start                          (start),
		.converter_clock_divider_select (sel),
		.interrupt_enable               (ie),
		.global_interrupt_enable        (ge),
		.request_flag_clear             (clr),
		.core_result                    (core_result),
		.core_power                     (core_power),
		.core_sample                    (core_sample),
		.core_convert_step              (core_step),
		.conversion_busy_flag           (busy),
		.request_flag                   (flag),
		.interrupt                      (irq),
		.conversion_done                (done),
		.result                         (result)
	);

	always #10 clock = ~clock;

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// cuts a hung wait short; the count is never reset and the whole simulation takes under 9000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			fails++;
			end_sim();
		end
	end

	task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic clear_flag;
		@(negedge clock) clr = 1'b1;
		@(negedge clock) clr = 1'b0;
		check("flag cleared", flag, 1'b0);
	endtask

	// one conversion; start held high h extra cycles before it falls
	task automatic conv(input logic [2:0] s, input logic i,
			input logic [11:0] v, input int h);
		int n;
		int steps;
		@(negedge clock);
		sel = s;
		ie = i;
		core_result = v;
		start = 1'b1;
		repeat (h + 1) @(negedge clock);
		check("busy while start high", busy, 1'b0);
		start = 1'b0;
		@(negedge clock);
		check("busy", busy, 1'b1);
		check("sampling", core_sample, 1'b1);
		n = 1;
		steps = 0;
		while (busy === 1'b1 && n < 4000) begin
			// a second pulse inside a conversion must be ignored
			start = (n == 3);
			@(negedge clock);
			steps += int'(core_step);
			n++;
		end
		check("length ok", 1'(n == (ACS_TOTAL_CLKS << s) ||
			n == (ACS_TOTAL_CLKS << s) + 1), 1'b1);
		check("steps", 12'(steps), 12'(ACS_CONVERT_CLKS));
		check("busy cleared", busy, 1'b0);
		check("done", done, 1'b1);
		check("request flag", flag, 1'b1);
		check("interrupt", irq, i & ge);
		check("result", result, v);
		repeat (3) @(negedge clock);
		check("no restart", busy, 1'b0);
		check("interrupt pulse", irq, 1'b0);
	endtask

	task automatic t_sweep;
		for (int s = 0; s < 8; s++) begin
			conv(3'(s), 1'b1, 12'(12'h0a5 + s * 12'h111), 0);
			clear_flag();
		end
	endtask

	task automatic t_masked;
		conv(3'h1, 1'b0, 12'hfff, 5);
		ge = 1'b0;
		clear_flag();
		conv(3'h0, 1'b1, 12'h001, 1);
		ge = 1'b1;
		clear_flag();
	endtask

	task automatic t_power;
		@(negedge clock) power = 1'b0;
		// 640 ns converter clock; long enough to drop power mid-run
		sel = 3'h5;
		start = 1'b1;
		@(negedge clock) start = 1'b0;
		repeat (4) @(negedge clock);
		check("off busy", busy, 1'b0);
		check("off core power", core_power, 1'b0);
		power = 1'b1;
		repeat (4) @(negedge clock); // settling delay
		check("on core power", core_power, 1'b1);
		start = 1'b1;
		@(negedge clock) start = 1'b0;
		repeat (20) @(negedge clock);
		check("busy before drop", busy, 1'b1);
		power = 1'b0;
		repeat (2) @(negedge clock);
		check("aborted", busy, 1'b0);
		repeat (140) begin
			@(negedge clock);
			check("abort done irq", 12'({done, irq}), 12'h000);
		end
		check("abort flag", flag, 1'b0);
		power = 1'b1;
		repeat (4) @(negedge clock);
	endtask

	// reset in mid-conversion returns everything to idle
	task automatic t_reset;
		@(negedge clock);
		sel = 3'h5;
		start = 1'b1;
		@(negedge clock) start = 1'b0;
		repeat (10) @(negedge clock);
		check("busy before reset", busy, 1'b1);
		rst = 1'b1;
		@(negedge clock);
		check("reset busy mid-run", busy, 1'b0);
		check("reset result mid-run", result, ACS_RESULT_0);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		check("idle after reset", busy, 1'b0);
		check("no done after reset", done, 1'b0);
	endtask

	initial begin
		repeat (2) @(negedge clock);
		check("reset busy", busy, 1'b0);
		check("reset flag", flag, 1'b0);
		check("reset result", result, 12'h000);
		rst = 1'b0;
		power = 1'b1;
		repeat (4) @(negedge clock); // settling delay
		t_sweep();
		t_masked();
		t_power();
		t_reset();
		t_sweep();
		end_sim();
	end
endmodule
`default_nettype wire
